/* rtl/sdmpd_core.sv */
// Purpose: serial dual-modulus pll divider core
// Assumes: i_clock far faster than reference and prescaled inputs
// Notes: shift logic runs on i_shift_clk; all else on i_clock
`timescale 1ns/10ps
`include "sdmpd_regs.svh"

module sdmpd_core
    import sdmpd_pkg::*;
(
    // system clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // serial programming link
    input wire logic i_shift_clk,
    input wire logic i_serial_data,
    input wire logic i_latch_load_strobe,
    // reference divide select pins
    input wire logic i_ref_div_sel_bit0,
    input wire logic i_ref_div_sel_bit1,
    input wire logic i_ref_div_sel_bit2,
    // reference and prescaled vco inputs
    input wire logic i_ref_osc_in,
    input wire logic i_prescaled_in,
    // reference and divider outputs
    output logic o_ref_osc_out,
    output logic o_ref_clk_buffered,
    output logic o_ref_div_out,
    output logic o_vco_div_out,
    // prescaler control
    output logic o_modulus_control,
    // phase and lock detectors
    output logic o_phase_err_tristate,
    output logic o_phase_err_tristate_oe,
    output logic o_phi_vco_n,
    output logic o_phi_ref_n,
    output logic o_lock_indicator,
    // open-drain band switches
    output logic o_band_switch_a,
    output logic o_band_switch_a_oe,
    output logic o_band_switch_b,
    output logic o_band_switch_b_oe
);
    import sdmpd_pkg::*;

    localparam sdmpd_word_s WORD_RST = '{
        sw_a: `SDMPD_SW_RST,
        sw_b: `SDMPD_SW_RST,
        a_cnt: `SDMPD_A_RST,
        n_cnt: `SDMPD_N_RST
    };

    function automatic logic [`SDMPD_RDIV_W-1:0] ref_divide(
        input logic [`SDMPD_SEL_W-1:0] sel
    );
        logic [`SDMPD_RDIV_W-1:0] v;
        unique case (sel)
            3'h0: v = `SDMPD_RDIV_0;
            3'h1: v = `SDMPD_RDIV_1;
            3'h2: v = `SDMPD_RDIV_2;
            3'h3: v = `SDMPD_RDIV_3;
            3'h4: v = `SDMPD_RDIV_4;
            3'h5: v = `SDMPD_RDIV_5;
            3'h6: v = `SDMPD_RDIV_6;
            3'h7: v = `SDMPD_RDIV_7;
        endcase
        return v;
    endfunction

    // link domain: reset follows the system reset through two flops
    logic sh_rst;
    sdmpd_shift_s sh_reg;
    sdmpd_shift_s sh_next;

    sdmpd_sync #(.W(1), .RST_VAL(1'h1)) u_sh_rst_sync (
        .i_clock(i_shift_clk),
        .i_rst(1'h0),
        .i_d(i_sys_rst),
        .o_q(sh_rst)
    );

    always_comb begin
        sh_next = sh_reg;
        sh_next.sr = {sh_reg.sr[`SDMPD_WORD_W-2:0], i_serial_data};
        // toggle marks that the word moved, for the crossing
        sh_next.tog = ~sh_reg.tog;
    end

    always_ff @(posedge i_shift_clk) begin
        if (sh_rst) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    // system domain: all pins except i_sys_rst pass two flops first
    sdmpd_pins_s pins_raw;
    sdmpd_pins_s pins;
    sdmpd_core_s st_reg;
    sdmpd_core_s st_next;
    sdmpd_word_s word_in;
    logic load_en;
    logic ref_edge;
    logic fin_edge;

    assign pins_raw = '{
        sel: {i_ref_div_sel_bit2, i_ref_div_sel_bit1, i_ref_div_sel_bit0},
        strobe: i_latch_load_strobe,
        ref_clk: i_ref_osc_in,
        fin: i_prescaled_in,
        tog: sh_reg.tog
    };

    sdmpd_sync #(.W($bits(sdmpd_pins_s)), .RST_VAL('0)) u_pin_sync (
        .i_clock(i_clock),
        .i_rst(i_sys_rst),
        .i_d(pins_raw),
        .o_q(pins)
    );

    assign word_in = sdmpd_word_s'(st_reg.snap);
    assign ref_edge = pins.ref_clk & ~st_reg.ref_d;
    assign fin_edge = pins.fin & ~st_reg.fin_d;
    // latches read only the local copy, never the live shift register
    assign load_en = pins.strobe;

    always_comb begin
        st_next = st_reg;
        st_next.fin_d = pins.fin;
        st_next.ref_d = pins.ref_clk;
        st_next.tog_d = pins.tog;
        st_next.ref_buf = pins.ref_clk;
        st_next.ref_tc = 1'h0;
        st_next.n_tc = 1'h0;
        // copy taken once the synced toggle moves: the word has stood
        // two cycles by then; shift clock must stay far below i_clock
        if (pins.tog != st_reg.tog_d) begin
            st_next.snap = sh_reg.sr;
        end

        if (load_en) begin
            st_next.latch = word_in;
        end

        if (ref_edge) begin
            if (st_reg.ref_cnt == '0) begin
                st_next.ref_cnt =
                    `SDMPD_RCNT_W'(ref_divide(pins.sel) - 1'h1);
                st_next.ref_tc = 1'h1;
            end else begin
                st_next.ref_cnt = st_reg.ref_cnt - 1'h1;
            end
        end

        if (fin_edge) begin
            if (st_reg.n_cnt <= `SDMPD_N_W'(1)) begin
                st_next.n_cnt = st_reg.latch.n_cnt;
                st_next.a_cnt = st_reg.latch.a_cnt;
                st_next.mc = (st_reg.latch.a_cnt == '0);
                st_next.n_tc = 1'h1;
            end else begin
                st_next.n_cnt = st_reg.n_cnt - 1'h1;
                if (st_reg.a_cnt != '0) begin
                    st_next.a_cnt = st_reg.a_cnt - 1'h1;
                end
                if (st_reg.a_cnt == `SDMPD_A_W'(1)) begin
                    st_next.mc = 1'h1;
                end
            end
        end

        // both set for one cycle, then clear; new end wins
        st_next.vco_flag = (st_reg.vco_flag & ~st_reg.ref_flag)
            | st_reg.n_tc;
        st_next.ref_flag = (st_reg.ref_flag & ~st_reg.vco_flag)
            | st_reg.ref_tc;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_reg <= '{
                latch: WORD_RST,
                n_cnt: `SDMPD_N_RST,
                a_cnt: `SDMPD_A_RST,
                default: '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_ref_clk_buffered = st_reg.ref_buf;
    assign o_ref_osc_out = ~st_reg.ref_buf;
    assign o_ref_div_out = st_reg.ref_tc;
    assign o_vco_div_out = st_reg.n_tc;
    assign o_modulus_control = st_reg.mc;
    // driven only when one side leads
    assign o_phase_err_tristate = st_reg.ref_flag;
    assign o_phase_err_tristate_oe = st_reg.vco_flag ^ st_reg.ref_flag;
    assign o_phi_vco_n = ~st_reg.vco_flag;
    assign o_phi_ref_n = ~st_reg.ref_flag;
    assign o_lock_indicator = ~(st_reg.vco_flag ^ st_reg.ref_flag);
    assign o_band_switch_a = 1'h0;
    assign o_band_switch_a_oe = ~st_reg.latch.sw_a;
    assign o_band_switch_b = 1'h0;
    assign o_band_switch_b_oe = ~st_reg.latch.sw_b;

    property p_shift_in;
        @(posedge i_shift_clk) disable iff (sh_rst)
        1 |=> sh_reg.sr == {$past(sh_reg.sr[17:0]), $past(i_serial_data)};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("shift register did not take data bit");

    property p_ref_reload;
        @(posedge i_clock) disable iff (i_sys_rst)
        ref_edge && st_reg.ref_cnt == '0 |=>
            st_reg.ref_tc && st_reg.ref_cnt ==
            `SDMPD_RCNT_W'(ref_divide($past(pins.sel)) - 1'h1);
    endproperty
    a_ref_reload: assert property (p_ref_reload)
        else $error("reference divider reload value wrong");

    property p_load;
        @(posedge i_clock) disable iff (i_sys_rst)
        load_en |=> st_reg.latch == $past(word_in);
    endproperty
    a_load: assert property (p_load)
        else $error("latch missed transfer while strobe high");

    property p_hold;
        @(posedge i_clock) disable iff (i_sys_rst)
        !pins.strobe |=> $stable(st_reg.latch);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch changed while strobe low");

    property p_count;
        @(posedge i_clock) disable iff (i_sys_rst)
        fin_edge && st_reg.n_cnt > 10'h001 |=>
            st_reg.n_cnt == $past(st_reg.n_cnt) - 10'h001;
    endproperty
    a_count: assert property (p_count)
        else $error("main counter did not decrement");

    property p_mc_rise;
        @(posedge i_clock) disable iff (i_sys_rst)
        fin_edge && st_reg.a_cnt == 7'h01 && st_reg.n_cnt > 10'h001
            |=> st_reg.mc && st_reg.a_cnt == '0;
    endproperty
    a_mc_rise: assert property (p_mc_rise)
        else $error("modulus control not raised after swallow");

    property p_mc_low;
        @(posedge i_clock) disable iff (i_sys_rst)
        st_reg.a_cnt != '0 |-> !o_modulus_control;
    endproperty
    a_mc_low: assert property (p_mc_low)
        else $error("modulus control high during swallow");

    property p_reload;
        @(posedge i_clock) disable iff (i_sys_rst)
        fin_edge && st_reg.n_cnt <= 10'h001 && st_reg.latch.a_cnt != '0
            |=> st_reg.n_tc && !st_reg.mc ##1 !st_reg.n_tc;
    endproperty
    a_reload: assert property (p_reload)
        else $error("cycle end did not reload with control low");

    property p_lead;
        @(posedge i_clock) disable iff (i_sys_rst)
        st_reg.n_tc && !st_reg.ref_tc && !st_reg.vco_flag
            && !st_reg.ref_flag |=> !o_phi_vco_n && o_phi_ref_n
            && !o_lock_indicator && o_phase_err_tristate_oe
            && !o_phase_err_tristate;
    endproperty
    a_lead: assert property (p_lead)
        else $error("vco lead not reported");

    property p_coincide;
        @(posedge i_clock) disable iff (i_sys_rst)
        !o_phi_vco_n && !o_phi_ref_n && !st_reg.n_tc && !st_reg.ref_tc
            |=> o_phi_vco_n && o_phi_ref_n && !o_phase_err_tristate_oe;
    endproperty
    a_coincide: assert property (p_coincide)
        else $error("coincident pulse wider than one cycle");

    property p_switch;
        @(posedge i_clock) disable iff (i_sys_rst)
        load_en |=> o_band_switch_a_oe == !$past(word_in.sw_a)
            && o_band_switch_b_oe == !$past(word_in.sw_b);
    endproperty
    a_switch: assert property (p_switch)
        else $error("band switch drive does not match latched bit");
endmodule

/* inc/sdmpd_regs.svh */
// Purpose: constants of the serial dual-modulus pll divider
// Assumes: included by the package and the core only
// Notes: field positions index the 19-bit serial word
`ifndef SDMPD_REGS_SVH
`define SDMPD_REGS_SVH

`define SDMPD_WORD_W 19
`define SDMPD_N_W 10
`define SDMPD_A_W 7
`define SDMPD_RCNT_W 11
`define SDMPD_RDIV_W 12
`define SDMPD_SEL_W 3

`define SDMPD_N_LSB 0
`define SDMPD_A_LSB 10
`define SDMPD_SWB_BIT 17
`define SDMPD_SWA_BIT 18

`define SDMPD_N_RST 10'h003
`define SDMPD_A_RST 7'h00
`define SDMPD_SW_RST 1'h1

`define SDMPD_RDIV_0 12'h008
`define SDMPD_RDIV_1 12'h040
`define SDMPD_RDIV_2 12'h080
`define SDMPD_RDIV_3 12'h100
`define SDMPD_RDIV_4 12'h280
`define SDMPD_RDIV_5 12'h3e8
`define SDMPD_RDIV_6 12'h400
`define SDMPD_RDIV_7 12'h800

`endif

/* inc/sdmpd_pkg.sv */
// Purpose: types of the serial dual-modulus pll divider
// Assumes: constants come from sdmpd_regs.svh
// Notes: word struct order matches shift register bit order
`include "sdmpd_regs.svh"

package sdmpd_pkg;

    typedef struct packed {
        logic sw_a;
        logic sw_b;
        logic [`SDMPD_A_W-1:0] a_cnt;
        logic [`SDMPD_N_W-1:0] n_cnt;
    } sdmpd_word_s;

    typedef struct packed {
        logic [`SDMPD_WORD_W-1:0] sr;
        logic tog;
    } sdmpd_shift_s;

    typedef struct packed {
        sdmpd_word_s latch;
        logic [`SDMPD_WORD_W-1:0] snap;
        logic [`SDMPD_RCNT_W-1:0] ref_cnt;
        logic ref_tc;
        logic [`SDMPD_N_W-1:0] n_cnt;
        logic [`SDMPD_A_W-1:0] a_cnt;
        logic mc;
        logic n_tc;
        logic vco_flag;
        logic ref_flag;
        logic fin_d;
        logic ref_d;
        logic tog_d;
        logic ref_buf;
    } sdmpd_core_s;

    typedef struct packed {
        logic [`SDMPD_SEL_W-1:0] sel;
        logic strobe;
        logic ref_clk;
        logic fin;
        logic tog;
    } sdmpd_pins_s;

endpackage

/* rtl/sdmpd_sync.sv */
// Purpose: two-flop level synchroniser, any width
// Assumes: inputs are quasi-static levels or slow edges
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps

module sdmpd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [1:0][W-1:0] st_reg;
    logic [1:0][W-1:0] st_next;

    always_comb begin
        st_next = {st_reg[0], i_d};
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_reg <= {RST_VAL, RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_q = st_reg[1];
endmodule

/* testbench/sdmpd_prescaler_model.sv */
// Purpose: dual-modulus prescaler facing the divider core
// Assumes: one vco tick every two system clock cycles
// Notes: modulus read late in each cycle, as a real prescaler does
`timescale 1ns/10ps

module sdmpd_prescaler_model #(
    parameter int P = 4
) (
    // system clock and run control
    input wire logic i_clock,
    input wire logic i_run,
    // modulus control from the core
    input wire logic i_modulus_control,
    // divided output to the core
    output logic o_prescaled
);
    logic tick_reg = 1'b0;
    int cnt_reg = 0;

    always @(negedge i_clock) begin
        if (i_run) begin
            tick_reg <= ~tick_reg;
            if (tick_reg) begin
                if (cnt_reg == P ||
                    (cnt_reg == P - 1 && i_modulus_control)) begin
                    cnt_reg <= 0;
                end else begin
                    cnt_reg <= cnt_reg + 1;
                end
            end
        end
    end

    // two ticks high, at least two low: above the core's minimum width
    assign o_prescaled = (cnt_reg < 2);
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the serial dual-modulus divider core
// Assumes: reference runs at a quarter of the system clock
// Notes: shift clock only runs while a word or link reset is sent
`timescale 1ns/10ps

module tb_top;
    import sdmpd_pkg::*;
    localparam int P = 4;
    int rtab[8] = '{8, 64, 128, 256, 640, 1000, 1024, 2048};
    int cn[3] = '{3, 1023, 5};
    int ca[3] = '{1, 127, 2};
    logic i_clock = 1'b0;
    logic i_ref_osc_in = 1'b0;
    logic rph = 1'b0;
    logic i_sys_rst, i_shift_clk, i_serial_data, i_latch_load_strobe;
    logic ref_en, fin_en, i_prescaled_in;
    logic [2:0] sel;
    logic o_ref_osc_out, o_ref_clk_buffered, o_ref_div_out, o_vco_div_out;
    logic o_modulus_control, o_phase_err_tristate, o_phase_err_tristate_oe;
    logic o_phi_vco_n, o_phi_ref_n, o_lock_indicator;
    logic o_band_switch_a, o_band_switch_a_oe;
    logic o_band_switch_b, o_band_switch_b_oe;
    logic [1:0] oe2;
    logic [4:0] det;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int cyc, aux, i;

    assign oe2 = {o_band_switch_a_oe, o_band_switch_b_oe};
    assign det = {o_phi_vco_n, o_phi_ref_n, o_lock_indicator,
                  o_phase_err_tristate_oe, o_phase_err_tristate};

    // no test pin on this core, so it stays in normal mode
    sdmpd_core DUT (
        .i_clock, .i_sys_rst, .i_shift_clk, .i_serial_data,
        .i_latch_load_strobe,
        .i_ref_div_sel_bit0(sel[0]),
        .i_ref_div_sel_bit1(sel[1]),
        .i_ref_div_sel_bit2(sel[2]),
        .i_ref_osc_in, .i_prescaled_in,
        .o_ref_osc_out, .o_ref_clk_buffered, .o_ref_div_out, .o_vco_div_out,
        .o_modulus_control, .o_phase_err_tristate, .o_phase_err_tristate_oe,
        .o_phi_vco_n, .o_phi_ref_n, .o_lock_indicator,
        .o_band_switch_a, .o_band_switch_a_oe,
        .o_band_switch_b, .o_band_switch_b_oe
    );

    sdmpd_prescaler_model #(.P(P)) PRE (
        .i_clock(i_clock),
        .i_run(fin_en),
        .i_modulus_control(o_modulus_control),
        .o_prescaled(i_prescaled_in)
    );

    always #2 i_clock = ~i_clock;

    // reference of four system cycles, stoppable
    always @(negedge i_clock) begin
        rph <= ~rph;
        if (ref_en && rph) begin
            i_ref_osc_in <= ~i_ref_osc_in;
        end
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 100000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            #31.25 i_shift_clk = 1'b1;
            #62.5 i_shift_clk = 1'b0;
            #31.25;
        end
    endtask

    // msb first; idle data shows the opposite of the last bit
    task automatic send(input logic [18:0] w);
        int b;
        for (b = 18; b >= 0; b--) begin
            i_serial_data = w[b];
            pulses(1);
        end
        i_serial_data = ~w[0];
    endtask

    task automatic load();
        @(negedge i_clock);
        i_latch_load_strobe = 1'b1;
        repeat (6) @(negedge i_clock);
        i_latch_load_strobe = 1'b0;
        repeat (6) @(negedge i_clock);
    endtask

    // cycles between two end pulses, with rises or modulus-low cycles
    task automatic span(input bit r, output int c, output int a);
        int k;
        logic pb;
        k = 0;
        c = 0;
        a = 0;
        while ((r ? o_ref_div_out : o_vco_div_out) !== 1'b1 && k < 20000) begin
            @(negedge i_clock);
            k++;
        end
        pb = o_ref_clk_buffered;
        do begin
            @(negedge i_clock);
            c++;
            if (r && o_ref_clk_buffered === 1'b1 && pb === 1'b0) a++;
            if (!r && o_modulus_control === 1'b0) a++;
            pb = o_ref_clk_buffered;
        end while ((r ? o_ref_div_out : o_vco_div_out) !== 1'b1 && c < 20000);
    endtask

    initial begin
        i_sys_rst = 1'b1;
        i_shift_clk = 1'b0;
        i_serial_data = 1'b0;
        i_latch_load_strobe = 1'b0;
        sel = 3'h0;
        ref_en = 1'b1;
        fin_en = 1'b1;
        repeat (16) @(negedge i_clock);
        pulses(3);
        @(negedge i_clock);
        i_sys_rst = 1'b0;
        pulses(3);
        @(negedge i_clock);
        chk({o_band_switch_a, o_band_switch_b, oe2}, 4'h0);
        $display("test reset done");
        send({1'b0, 1'b1, 7'h05, 10'h0aa});
        chk(oe2, 2'h0);
        load();
        chk(oe2, 2'h2);
        send({1'b1, 1'b0, 7'h11, 10'h155});
        chk(oe2, 2'h2);
        load();
        chk(oe2, 2'h1);
        @(negedge i_clock);
        i_latch_load_strobe = 1'b1;
        send({1'b0, 1'b0, 7'h01, 10'h003});
        repeat (8) @(negedge i_clock);
        chk(oe2, 2'h3);
        i_latch_load_strobe = 1'b0;
        $display("test latch done");
        for (i = 0; i < 3; i++) begin
            send({2'h3, 7'(ca[i]), 10'(cn[i])});
            load();
            span(1'b0, cyc, aux);
            chk(cyc, 2 * (cn[i] * P + ca[i]));
            chk(aux, 2 * ca[i] * (P + 1));
        end
        $display("test counters done");
        fin_en = 1'b0;
        repeat (200) @(negedge i_clock);
        chk(det, 5'h13);
        ref_en = 1'b0;
        fin_en = 1'b1;
        repeat (200) @(negedge i_clock);
        chk(det, 5'h0a);
        ref_en = 1'b1;
        $display("test detectors done");
        for (i = 0; i < 8; i++) begin
            sel = 3'(i);
            // let the new select pass the two sync flops before the next reload
            repeat (3) @(negedge i_clock);
            span(1'b1, cyc, aux);
            chk(cyc, rtab[i] * 4);
            chk(aux, rtab[i]);
            chk(o_ref_osc_out, 1'(~o_ref_clk_buffered));
        end
        $display("test reference done");
        report_and_stop();
    end
endmodule
